// ===== hdl/shrs_pkg.sv
// shrs_pkg: constants and types shared by the holding register slave and its fifo.
// assumes the byte framing, the frame gap timing and the crc arithmetic live outside.
package shrs_pkg;

  // function codes that the slave answers
  localparam logic [7:0] FUNC_READ = 8'h03; // read holding registers
  localparam logic [7:0] FUNC_WRITE = 8'h06; // write one holding register
  localparam logic [7:0] FUNC_DIAG = 8'h08; // diagnostic echo
  localparam logic [15:0] SUBF_ECHO = 16'h0000; // return query data
  localparam logic [7:0] BCAST_ADDR = 8'h00; // broadcast station address

  // error answers
  localparam logic [7:0] ERR_FLAG = 8'h80; // added to the function code
  localparam logic [7:0] EXC_ILL_FUNC = 8'h01; // unsupported function or subfunction
  localparam logic [7:0] EXC_ILL_DATA = 8'h03; // register count out of range

  // register numbering: number = address field + 40001
  localparam logic [16:0] REG_BASE = 17'h09c41; // 40001 decimal

  // read limits: byte count field runs from 2 to 20
  localparam logic [7:0] BYTE_CNT_MIN = 8'h02; // smallest byte count
  localparam logic [7:0] BYTE_CNT_MAX = 8'h14; // largest byte count
  localparam logic [15:0] REG_CNT_MIN = 16'h0001; // fewest registers per read
  localparam logic [15:0] REG_CNT_MAX = 16'h000a; // most registers per read

  // framing
  localparam logic [3:0] QUERY_LEN = 4'h8; // bytes in every supported query
  localparam logic [3:0] FUNC_MIN_LEN = 4'h4; // shortest frame worth an error answer
  localparam logic [3:0] LAST_IDX = 4'h7; // index of the last query byte
  localparam logic [3:0] HDR_LAST = 4'h2; // index of the last header byte

  // buffering
  localparam int FIFO_DEPTH = 16; // words in the transmit fifo
  localparam int FIFO_WIDTH = 10; // {add_crc, last, data}

  // reset values
  localparam logic [3:0] IDX_RST = 4'h0; // byte index after reset
  localparam logic [16:0] NUM_RST = 17'h00000; // register number after reset
  localparam logic [15:0] DATA_RST = 16'h0000; // data words after reset
  localparam logic [7:0] BYTE_RST = 8'h00; // buffer bytes after reset

  // sequencer states, gray steps along receive, header, request, wait, data
  typedef enum logic [3:0] {
    ST_RECV = 4'h0, // collecting a query
    ST_RHDR = 4'h1, // sending read header
    ST_RREQ = 4'h3, // asking for one register
    ST_RWAIT = 4'h2, // waiting for register data
    ST_RDATA = 4'h6, // sending register high then low
    ST_WRITE = 4'h4, // strobing a single write
    ST_ECHO = 4'h5, // echoing the query
    ST_ERR = 4'hc // sending an error answer
  } shrs_state_type;

endpackage : shrs_pkg

// ===== hdl/shrs_fifo.sv
// shrs_fifo: flip-flop fifo with valid and ready on both sides.
// assumes one clock and a synchronised active-low reset copy from the parent.
`timescale 1ns/1ps
module shrs_fifo #(
  parameter int WIDTH = 10, // word width
  parameter int DEPTH = 16 // word count, a power of two
) (
  input wire logic mclk, // system clock
  input wire logic rst_n, // synchronised reset, active low
  input wire logic in_valid, // word offered
  output logic in_ready, // room for a word
  input wire logic [WIDTH-1:0] in_data, // word written
  output logic out_valid, // word available
  input wire logic out_ready, // drain side takes the word
  output logic [WIDTH-1:0] out_data // oldest word
);

  localparam int AW = $clog2(DEPTH); // pointer index width, the pointers carry one more bit for wrap

  logic [WIDTH-1:0] mem_q [DEPTH]; // storage
  logic [AW:0] wr_ptr_q; // write pointer with wrap bit
  logic [AW:0] rd_ptr_q; // read pointer with wrap bit
  wire logic full_w = (wr_ptr_q[AW] != rd_ptr_q[AW]) && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
  wire logic empty_w = (wr_ptr_q == rd_ptr_q); // nothing stored
  wire logic push_w = in_valid && !full_w; // word written this cycle
  wire logic pop_w = out_ready && !empty_w; // word leaves this cycle

  assign in_ready = !full_w;
  assign out_valid = !empty_w;
  assign out_data = mem_q[rd_ptr_q[AW-1:0]];

  // pointers move on each accepted word
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push_w) wr_ptr_q <= wr_ptr_q + 1'b1;
      if (pop_w) rd_ptr_q <= rd_ptr_q + 1'b1;
    end
  end

  // storage needs no reset, only written words are ever read
  always_ff @(posedge mclk) begin
    if (push_w) mem_q[wr_ptr_q[AW-1:0]] <= in_data;
  end

endmodule : shrs_fifo

// ===== hdl/shrs_slave.sv
// shrs_slave: query interpreter for a serial holding register slave station.
// assumes a byte receiver on mclk that flags the end of frame and crc result,
// and a byte sender that appends the crc (low byte first) when tx_add_crc is set.
// Summary of operation
// RULE_01 - read query: address, 03, start, count, crc
// RULE_02 - read register number is start plus 40001
// RULE_03 - master asks at most 125 registers
// RULE_04 - read and diagnostic never broadcast
// RULE_05 - byte count twice register count, 2..20
// RULE_06 - high byte first, ascending registers
// RULE_07 - write query: address, 06, register, data, crc
// RULE_08 - write register number is field plus 40001
// RULE_09 - broadcast single write is performed
// RULE_10 - addressed write answered with identical frame
// RULE_11 - no answer to any broadcast
// RULE_12 - master waits processing time after broadcast
// RULE_13 - diagnostic subfunction 0000 echoes the frame
// RULE_14 - diagnostic data two bytes, any value
// RULE_15 - crc sent low byte then high
// RULE_16 - unsupported function gets error answer
// RULE_17 - foreign station addresses are ignored
`timescale 1ns/1ps
module shrs_slave (
  input wire logic mclk, // 100 MHz system clock
  input wire logic resetn, // asynchronous reset, active low
  input wire logic [7:0] station_addr, // own station number
  input wire logic rx_valid, // one received byte, pulse
  input wire logic [7:0] rx_data, // received byte
  input wire logic rx_end, // frame gap seen, pulse
  input wire logic rx_crc_ok, // crc matched, valid with rx_end
  output logic tx_valid, // byte to send
  output logic [7:0] tx_data, // byte value
  output logic tx_last, // last byte of the answer
  output logic tx_add_crc, // sender appends crc after this byte
  input wire logic tx_ready, // sender takes the byte
  output logic reg_rd_en, // register read strobe, pulse
  output logic reg_wr_en, // register write strobe, pulse
  output logic [16:0] reg_num, // decimal register number
  output logic [15:0] reg_wdata, // data to write
  input wire logic [15:0] reg_rd_data, // read data
  input wire logic reg_rd_valid, // read data valid, pulse
  output logic busy // query being served
);

  // reset release through two flops, the second is the copy everyone uses
  logic rst_meta_q; // first stage
  logic rst_n; // released reset
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  shrs_pkg::shrs_state_type state_q, state_d; // sequencer
  logic [7:0] buf_q [8]; // query bytes
  logic [3:0] idx_q, idx_d; // byte index, receive or send
  logic over_q, over_d; // query longer than any supported
  logic [3:0] rcnt_q, rcnt_d; // registers already sent
  logic half_q, half_d; // low byte of the current register
  logic [15:0] rdata_q, rdata_d; // captured register value
  logic [7:0] exc_q, exc_d; // exception code for error answers
  logic reg_rd_en_q, reg_wr_en_q, busy_q; // strobes and status
  logic [16:0] reg_num_q, reg_num_d; // register number
  logic [15:0] reg_wdata_q; // write data

  // field decode of the stored query
  wire logic [7:0] addr_w = buf_q[0]; // station address
  wire logic [7:0] func_w = buf_q[1]; // function code
  wire logic [15:0] field_a = {buf_q[2], buf_q[3]}; // start, register or subfunction
  wire logic [15:0] field_b = {buf_q[4], buf_q[5]}; // count or data
  wire logic is_bcast = (addr_w == shrs_pkg::BCAST_ADDR); // broadcast query
  // RULE_17 station match
  wire logic addr_hit = is_bcast || (addr_w == station_addr);
  wire logic is_read = (func_w == shrs_pkg::FUNC_READ); // read query
  wire logic is_write = (func_w == shrs_pkg::FUNC_WRITE); // single write
  wire logic is_diag = (func_w == shrs_pkg::FUNC_DIAG); // diagnostic
  // RULE_16 supported code check
  wire logic known_func = is_read || is_write || is_diag;
  // RULE_03 count range check
  wire logic cnt_ok = (field_b >= shrs_pkg::REG_CNT_MIN) && (field_b <= shrs_pkg::REG_CNT_MAX);
  // RULE_05 doubled count
  wire logic [7:0] byte_cnt = {field_b[6:0], 1'b0};
  wire logic len_ok = (idx_q == shrs_pkg::QUERY_LEN) && !over_q; // exact length
  wire logic frame_good = rx_crc_ok && !over_q && (idx_q >= shrs_pkg::FUNC_MIN_LEN);
  wire logic regs_last = (rcnt_q == (field_b[3:0] - 4'h1)); // final register

  // byte offered to the transmit fifo
  wire logic in_echo = (state_q == shrs_pkg::ST_ECHO); // echo in progress
  wire logic in_rhdr = (state_q == shrs_pkg::ST_RHDR); // read header
  wire logic in_rdata = (state_q == shrs_pkg::ST_RDATA); // read data
  wire logic in_err = (state_q == shrs_pkg::ST_ERR); // error answer
  wire logic push_valid = in_echo || in_rhdr || in_rdata || in_err;
  wire logic [7:0] hdr_byte = (idx_q == 4'h0) ? addr_w : (idx_q == 4'h1) ? func_w : byte_cnt;
  wire logic [7:0] err_byte = (idx_q == 4'h0) ? addr_w :
                              (idx_q == 4'h1) ? (func_w | shrs_pkg::ERR_FLAG) : exc_q;
  // RULE_06 high before low
  wire logic [7:0] dat_byte = half_q ? rdata_q[7:0] : rdata_q[15:8];
  // RULE_14 data echoed untouched
  wire logic [7:0] push_data = in_echo ? buf_q[idx_q[2:0]] : in_rhdr ? hdr_byte :
                               in_rdata ? dat_byte : err_byte;
  wire logic push_last = (in_echo && (idx_q == shrs_pkg::LAST_IDX)) ||
                         (in_rdata && half_q && regs_last) ||
                         (in_err && (idx_q == shrs_pkg::HDR_LAST));
  // RULE_15 sender adds crc
  wire logic push_crc = push_last && !in_echo;
  logic fifo_ready; // transmit fifo has room
  wire logic push_fire = push_valid && fifo_ready; // byte accepted
  logic [9:0] fifo_out; // {add_crc, last, data}

  // next state and counters
  always_comb begin
    state_d = state_q;
    idx_d = idx_q;
    over_d = over_q;
    rcnt_d = rcnt_q;
    half_d = half_q;
    rdata_d = rdata_q;
    exc_d = exc_q;
    case (state_q)
      shrs_pkg::ST_RECV: begin
        if (rx_valid) begin
          if (idx_q < shrs_pkg::QUERY_LEN) begin
            idx_d = idx_q + 4'h1;
          end else begin
            over_d = 1'b1;
          end
        end else if (rx_end) begin
          idx_d = shrs_pkg::IDX_RST;
          over_d = 1'b0;
          // RULE_17 drop foreign frames
          if (!frame_good || !addr_hit) begin
            state_d = shrs_pkg::ST_RECV;
          end else if (!known_func) begin
            // RULE_11 silent broadcast error
            state_d = is_bcast ? shrs_pkg::ST_RECV : shrs_pkg::ST_ERR;
            exc_d = shrs_pkg::EXC_ILL_FUNC;
          end else if (!len_ok) begin
            state_d = shrs_pkg::ST_RECV; // malformed length, ignored like a framing fault
          end else if (is_write) begin
            // RULE_09 broadcast writes too
            state_d = shrs_pkg::ST_WRITE;
          end else if (is_bcast) begin
            // RULE_04 no broadcast read
            state_d = shrs_pkg::ST_RECV;
          end else if (is_read) begin
            // RULE_01 read decode
            state_d = cnt_ok ? shrs_pkg::ST_RHDR : shrs_pkg::ST_ERR;
            exc_d = shrs_pkg::EXC_ILL_DATA;
          end else begin
            // RULE_13 echo only subfunction zero
            state_d = (field_a == shrs_pkg::SUBF_ECHO) ? shrs_pkg::ST_ECHO : shrs_pkg::ST_ERR;
            exc_d = shrs_pkg::EXC_ILL_FUNC;
          end
        end
      end
      shrs_pkg::ST_WRITE: begin
        // RULE_10 echo addressed write
        state_d = is_bcast ? shrs_pkg::ST_RECV : shrs_pkg::ST_ECHO;
      end
      shrs_pkg::ST_ECHO, shrs_pkg::ST_ERR: begin
        if (push_fire) begin
          idx_d = push_last ? shrs_pkg::IDX_RST : idx_q + 4'h1;
          state_d = push_last ? shrs_pkg::ST_RECV : state_q;
        end
      end
      shrs_pkg::ST_RHDR: begin
        if (push_fire) begin
          idx_d = (idx_q == shrs_pkg::HDR_LAST) ? shrs_pkg::IDX_RST : idx_q + 4'h1;
          state_d = (idx_q == shrs_pkg::HDR_LAST) ? shrs_pkg::ST_RREQ : state_q;
          rcnt_d = 4'h0;
        end
      end
      shrs_pkg::ST_RREQ: begin
        state_d = shrs_pkg::ST_RWAIT;
      end
      shrs_pkg::ST_RWAIT: begin
        if (reg_rd_valid) begin
          rdata_d = reg_rd_data;
          half_d = 1'b0;
          state_d = shrs_pkg::ST_RDATA;
        end
      end
      shrs_pkg::ST_RDATA: begin
        if (push_fire) begin
          half_d = !half_q;
          if (half_q) begin
            // RULE_06 ascending registers
            rcnt_d = rcnt_q + 4'h1;
            state_d = regs_last ? shrs_pkg::ST_RECV : shrs_pkg::ST_RREQ;
          end
        end
      end
      default: begin
        state_d = shrs_pkg::ST_RECV;
        idx_d = shrs_pkg::IDX_RST;
      end
    endcase
  end

  // register number for the next strobe
  always_comb begin
    reg_num_d = reg_num_q;
    if (state_q == shrs_pkg::ST_RREQ) begin
      // RULE_02 read numbering
      reg_num_d = 17'(field_a) + shrs_pkg::REG_BASE + 17'(rcnt_q);
    end else if (state_q == shrs_pkg::ST_WRITE) begin
      // RULE_08 write numbering
      reg_num_d = 17'(field_a) + shrs_pkg::REG_BASE;
    end
  end

  // sequencer registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= shrs_pkg::ST_RECV;
      idx_q <= shrs_pkg::IDX_RST;
      over_q <= 1'b0;
      rcnt_q <= 4'h0;
      half_q <= 1'b0;
      rdata_q <= shrs_pkg::DATA_RST;
      exc_q <= shrs_pkg::BYTE_RST;
    end else begin
      state_q <= state_d;
      idx_q <= idx_d;
      over_q <= over_d;
      rcnt_q <= rcnt_d;
      half_q <= half_d;
      rdata_q <= rdata_d;
      exc_q <= exc_d;
    end
  end

  // query bytes are stored only while receiving, later bytes are dropped
  for (genvar i = 0; i < 8; i++) begin : g_buf
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        buf_q[i] <= shrs_pkg::BYTE_RST;
      end else if (state_q == shrs_pkg::ST_RECV && rx_valid && idx_q == 4'(i)) begin
        buf_q[i] <= rx_data;
      end
    end
  end

  // register port strobes, one cycle each
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rd_en_q <= 1'b0;
      reg_wr_en_q <= 1'b0;
      reg_num_q <= shrs_pkg::NUM_RST;
      reg_wdata_q <= shrs_pkg::DATA_RST;
      busy_q <= 1'b0;
    end else begin
      reg_rd_en_q <= (state_q == shrs_pkg::ST_RREQ);
      // RULE_07 two data bytes
      reg_wr_en_q <= (state_q == shrs_pkg::ST_WRITE);
      reg_num_q <= reg_num_d;
      if (state_q == shrs_pkg::ST_WRITE) reg_wdata_q <= field_b;
      busy_q <= (state_d != shrs_pkg::ST_RECV);
    end
  end

  // answers queue here so a slow sender stalls the sequencer, not the data
  shrs_fifo #(
    .WIDTH(shrs_pkg::FIFO_WIDTH),
    .DEPTH(shrs_pkg::FIFO_DEPTH)
  ) u_tx_fifo (
    .mclk(mclk),
    .rst_n(rst_n),
    .in_valid(push_valid),
    .in_ready(fifo_ready),
    .in_data({push_crc, push_last, push_data}),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .out_data(fifo_out)
  );

  assign tx_data = fifo_out[7:0];
  assign tx_last = fifo_out[8];
  assign tx_add_crc = fifo_out[9];
  assign reg_rd_en = reg_rd_en_q;
  assign reg_wr_en = reg_wr_en_q;
  assign reg_num = reg_num_q;
  assign reg_wdata = reg_wdata_q;
  assign busy = busy_q;

  // checks on the sequencer
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_rd_num;
    reg_rd_en_q |-> reg_num_q == 17'(field_a) + shrs_pkg::REG_BASE + 17'(rcnt_q);
  endproperty
  a_rd_num: assert property (p_rd_num) else $error("read register number wrong"); // RULE_02

  property p_wr_num;
    reg_wr_en_q |-> (reg_num_q == 17'(field_a) + shrs_pkg::REG_BASE) && (reg_wdata_q == field_b);
  endproperty
  a_wr_num: assert property (p_wr_num) else $error("write number or data wrong"); // RULE_08

  property p_bcast_write;
    (state_q == shrs_pkg::ST_RECV && rx_end && frame_good && len_ok && is_bcast && is_write)
      |-> ##2 reg_wr_en_q ##1 (state_q == shrs_pkg::ST_RECV);
  endproperty
  a_bcast_write: assert property (p_bcast_write) else $error("broadcast write lost"); // RULE_09

  property p_no_bcast_tx;
    push_valid |-> !is_bcast;
  endproperty
  a_no_bcast_tx: assert property (p_no_bcast_tx) else $error("answer to broadcast"); // RULE_11

  property p_byte_cnt;
    (push_fire && in_rhdr && idx_q == shrs_pkg::HDR_LAST) |->
      push_data == {field_b[6:0], 1'b0} && push_data >= shrs_pkg::BYTE_CNT_MIN &&
      push_data <= shrs_pkg::BYTE_CNT_MAX;
  endproperty
  a_byte_cnt: assert property (p_byte_cnt) else $error("byte count wrong"); // RULE_05

  property p_foreign;
    (state_q == shrs_pkg::ST_RECV && rx_end && !addr_hit) |=> state_q == shrs_pkg::ST_RECV [*2];
  endproperty
  a_foreign: assert property (p_foreign) else $error("foreign query served"); // RULE_17

  property p_echo;
    (push_valid && in_echo) |-> push_data == buf_q[idx_q[2:0]] && !push_crc &&
      idx_q <= shrs_pkg::LAST_IDX && (push_last == (idx_q == shrs_pkg::LAST_IDX));
  endproperty
  a_echo: assert property (p_echo) else $error("echo byte differs"); // RULE_10

  property p_err_func;
    (push_valid && in_err && idx_q == 4'h1) |-> push_data == (func_w | shrs_pkg::ERR_FLAG);
  endproperty
  a_err_func: assert property (p_err_func) else $error("error function byte wrong"); // RULE_16

  property p_hi_lo;
    (push_fire && in_rdata && !half_q) |=> push_valid && half_q &&
      push_data == $past(rdata_q[7:0]);
  endproperty
  a_hi_lo: assert property (p_hi_lo) else $error("register bytes out of order"); // RULE_06

  property p_crc_tail;
    (push_valid && push_last && !in_echo) |-> push_crc;
  endproperty
  a_crc_tail: assert property (p_crc_tail) else $error("crc not requested"); // RULE_15

  property p_diag_echo;
    (state_q == shrs_pkg::ST_RECV && rx_end && frame_good && len_ok && !is_bcast && addr_hit &&
     is_diag && field_a == shrs_pkg::SUBF_ECHO) |=> state_q == shrs_pkg::ST_ECHO;
  endproperty
  a_diag_echo: assert property (p_diag_echo) else $error("diagnostic not echoed"); // RULE_13

  c_read: cover property (push_fire && in_rdata && push_last);
  c_write_echo: cover property (reg_wr_en_q ##1 in_echo);
  c_error: cover property (push_fire && in_err && push_last);
  c_stall: cover property (push_valid && !fifo_ready);

endmodule : shrs_slave

// ===== bench/shrs_master_model.sv
// shrs_master_model: remote master that sends queries and sinks the answers.
// assumes the slave takes one byte per rx_valid pulse and answers on valid/ready.
`timescale 1ns/1ps
module shrs_master_model (
  input wire logic mclk, // system clock
  input wire logic hold, // stalls the sink completely
  output logic rx_valid, // query byte strobe
  output logic [7:0] rx_data, // query byte
  output logic rx_end, // frame gap strobe
  output logic rx_crc_ok, // crc verdict with rx_end
  input wire logic tx_valid, // answer byte offered
  input wire logic [7:0] tx_data, // answer byte
  input wire logic tx_last, // last answer byte
  input wire logic tx_add_crc, // sender appends crc
  output logic tx_ready // sink takes the byte
);
  logic [9:0] got_q[$]; // answer words as {add_crc, last, data}

  // idle link levels
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_end = 1'b0;
    rx_crc_ok = 1'b0;
    tx_ready = 1'b0;
  end

  // bytes in field order, crc low then high
  task automatic send(input logic [7:0] b [8], input logic ok);
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk);
      rx_valid <= 1'b1;
      rx_data <= b[i];
      @(posedge mclk);
      rx_valid <= 1'b0;
      // released data line must not keep showing the byte
      rx_data <= ~b[i];
    end
    @(posedge mclk);
    rx_end <= 1'b1;
    rx_crc_ok <= ok;
    @(posedge mclk);
    rx_end <= 1'b0;
    rx_crc_ok <= ~ok;
  endtask : send

  // sink stalls at random so the fifo sees back pressure
  always @(posedge mclk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      got_q.push_back({tx_add_crc, tx_last, tx_data});
    end
    tx_ready <= !hold && ($urandom_range(3) != 0);
  end
endmodule : shrs_master_model

// ===== bench/test_serial_holding_register_slave.sv
// test_serial_holding_register_slave: random and corner queries against the slave.
// assumes the crc is worked outside, so rx_crc_ok is set by the master model.
`timescale 1ns/1ps
module test_serial_holding_register_slave;
  logic mclk; // 100 MHz clock
  logic resetn; // reset, active low
  logic [7:0] st; // own station number
  logic hold; // sink stall request
  logic rx_valid, rx_end, rx_crc_ok, tx_valid, tx_last, tx_add_crc, tx_ready; // link
  logic [7:0] rx_data, tx_data; // link bytes
  logic reg_rd_en, reg_wr_en, reg_rd_valid, busy; // register side strobes
  logic [16:0] reg_num; // register number
  logic [15:0] reg_wdata, reg_rd_data; // register data
  logic [9:0] exp_q[$]; // expected answer words
  logic [16:0] rd_q[$], exp_rd[$]; // seen and expected read numbers
  logic [32:0] wr_q[$], exp_wr[$]; // seen and expected writes
  logic [7:0] fns [4] = '{8'h03, 8'h06, 8'h08, 8'h2b}; // function mix
  int fail_count = 0; // mismatches
  int checks = 0; // comparisons

  shrs_slave dut_u (.mclk(mclk), .resetn(resetn), .station_addr(st), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_end(rx_end), .rx_crc_ok(rx_crc_ok), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last), .tx_add_crc(tx_add_crc), .tx_ready(tx_ready),
    .reg_rd_en(reg_rd_en), .reg_wr_en(reg_wr_en), .reg_num(reg_num), .reg_wdata(reg_wdata),
    .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid), .busy(busy));
  shrs_master_model master_u (.mclk(mclk), .hold(hold), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_end(rx_end), .rx_crc_ok(rx_crc_ok), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last), .tx_add_crc(tx_add_crc), .tx_ready(tx_ready));

  // clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // register contents seen by reads, kept simple so any number has a known value
  function automatic logic [15:0] rd_value(input logic [16:0] n);
    return n[15:0] ^ 16'h5a3c;
  endfunction : rd_value

  // register store stand-in: answers each read after 0..3 cycles
  initial begin
    reg_rd_valid = 1'b0;
    reg_rd_data = 16'h0000;
    forever begin
      @(posedge mclk);
      if (reg_rd_en === 1'b1) begin
        rd_q.push_back(reg_num);
        repeat ($urandom_range(3)) @(posedge mclk);
        reg_rd_valid <= 1'b1;
        reg_rd_data <= rd_value(rd_q[$]);
        @(posedge mclk);
        reg_rd_valid <= 1'b0;
        reg_rd_data <= ~rd_value(rd_q[$]);
      end
    end
  end

  // write strobes are logged for comparison
  always @(posedge mclk) begin
    if (reg_wr_en === 1'b1) begin
      wr_q.push_back({reg_num, reg_wdata});
    end
  end

  task automatic check_word(input logic [9:0] got, input logic [9:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : check_word

  task automatic check_val(input logic [32:0] got, input logic [32:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : check_val

  task automatic stop_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  // answer word with last and add_crc both set on the final byte
  task automatic push(input logic [7:0] b, input logic t);
    exp_q.push_back({t, t, b});
  endtask : push

  // one query: expectations from the protocol, then send, wait and compare
  task automatic query(input logic [7:0] adr, input logic [7:0] fn, input logic [15:0] fa,
    input logic [15:0] fb, input logic ok);
    logic [7:0] qb [8];
    logic own;
    logic [16:0] n;
    logic [15:0] v;
    int k;
    own = ok && (adr == st);
    qb = '{adr, fn, fa[15:8], fa[7:0], fb[15:8], fb[7:0], 8'($urandom), 8'($urandom)};
    if (own && fn == shrs_pkg::FUNC_READ && fb >= 16'h0001 && fb <= 16'h000a) begin
      push(adr, 1'b0);
      push(fn, 1'b0);
      push(8'(fb * 16'h0002), 1'b0);
      for (int i = 0; i < int'(fb); i++) begin
        n = shrs_pkg::REG_BASE + 17'(fa) + 17'(i);
        v = rd_value(n);
        exp_rd.push_back(n);
        push(v[15:8], 1'b0);
        push(v[7:0], i == int'(fb) - 1);
      end
    end else if (own && (fn == shrs_pkg::FUNC_DIAG) && fa == shrs_pkg::SUBF_ECHO
      || own && fn == shrs_pkg::FUNC_WRITE) begin
      for (int i = 0; i < 8; i++) begin
        exp_q.push_back({1'b0, i == 7, qb[i]});
      end
    end else if (own) begin
      push(adr, 1'b0);
      push(fn | shrs_pkg::ERR_FLAG, 1'b0);
      push(fn == shrs_pkg::FUNC_READ ? shrs_pkg::EXC_ILL_DATA : shrs_pkg::EXC_ILL_FUNC, 1'b1);
    end
    if (ok && (own || adr == shrs_pkg::BCAST_ADDR) && fn == shrs_pkg::FUNC_WRITE) begin
      exp_wr.push_back({shrs_pkg::REG_BASE + 17'(fa), fb});
    end
    master_u.send(qb, ok);
    repeat (3) @(posedge mclk);
    // next query only once the slave has settled
    for (k = 0; k < 3000; k++) begin
      if (busy === 1'b0 && master_u.got_q.size() >= exp_q.size()) break;
      @(posedge mclk);
    end
    if (k == 3000) begin
      fail_count++;
      stop_test();
    end
    repeat (30) @(posedge mclk);
    check_val(33'(master_u.got_q.size()), 33'(exp_q.size()));
    foreach (exp_q[i]) begin
      if (i < master_u.got_q.size()) check_word(master_u.got_q[i], exp_q[i]);
    end
    check_val(33'(rd_q.size()), 33'(exp_rd.size()));
    foreach (exp_rd[i]) if (i < rd_q.size()) check_val(33'(rd_q[i]), 33'(exp_rd[i]));
    check_val(33'(wr_q.size()), 33'(exp_wr.size()));
    foreach (exp_wr[i]) if (i < wr_q.size()) check_val(wr_q[i], exp_wr[i]);
    master_u.got_q.delete();
    exp_q.delete();
    rd_q.delete();
    exp_rd.delete();
    wr_q.delete();
    exp_wr.delete();
  endtask : query

  // main sequence: corners first, then a random mix
  initial begin
    void'($urandom(32'hb502));
    resetn = 1'b0;
    hold = 1'b0;
    st = 8'($urandom_range(247, 1));
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    repeat (4) @(posedge mclk);
    query(st, 8'h03, 16'h03eb, 16'h0003, 1'b1);
    query(st, 8'h03, 16'hffff, 16'h0001, 1'b1);
    hold <= 1'b1;
    fork
      begin
        repeat (200) @(posedge mclk);
        hold <= 1'b0;
      end
    join_none
    query(st, 8'h03, 16'h0000, 16'h000a, 1'b1);
    query(st, 8'h03, 16'h0010, 16'h0000, 1'b1);
    query(st, 8'h03, 16'h0010, 16'h000b, 1'b1);
    // largest count a master may ask for
    query(st, 8'h03, 16'h0020, 16'h007d, 1'b1);
    query(8'h00, 8'h03, 16'h0001, 16'h0002, 1'b1);
    query(st, 8'h06, 16'h000d, 16'h1770, 1'b1);
    query(8'h00, 8'h06, 16'h0044, 16'hbeef, 1'b1);
    query(st, 8'h08, 16'h0000, 16'h0000, 1'b1);
    query(st, 8'h08, 16'h0000, 16'hffff, 1'b1);
    query(st, 8'h08, 16'h0001, 16'h1234, 1'b1);
    query(8'h00, 8'h08, 16'h0000, 16'h55aa, 1'b1);
    query(st, 8'h46, 16'h0000, 16'h0000, 1'b1);
    query(8'h00, 8'h46, 16'h0000, 16'h0000, 1'b1);
    query(st + 8'h01, 8'h06, 16'h0003, 16'h0007, 1'b1);
    query(st, 8'h06, 16'h0003, 16'h0007, 1'b0);
    for (int r = 0; r < 24; r++) begin
      query(st, fns[$urandom_range(3)], 16'($urandom), 16'($urandom_range(12)), 1'b1);
    end
    stop_test();
  end
endmodule : test_serial_holding_register_slave
